// ---- inc/tdmsp_pkg.sv ----
// Constants for the TDM slot DMA serial port.
// Assumes a 60 MHz core clock, a 100 MHz port clock and a codec-driven bit clock.
package tdmsp_pkg;
    localparam int SLOT_BITS = 16;
    localparam int SLOTS = 16;
    localparam int TX_WORDS = 7;
    localparam int RX_WORDS = 5;
    localparam logic [31:0] RX_MASK_RST = 32'h0000001f;
    localparam logic [31:0] TX_MASK_RST = 32'h0000007f;
    localparam logic [15:0] TAG_RST = 16'he000;
    localparam logic [15:0] CMD_RST = 16'h7400;
    localparam logic [15:0] DATA_RST = 16'hff80;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam int TAG_DEADLINE_CYC = 75;
    localparam int CORE_MHZ = 60;
    localparam int CLK_MHZ = 100;
    localparam int TAG_DEADLINE_NS = (TAG_DEADLINE_CYC * 1000) / CORE_MHZ;
    localparam int TAG_DEADLINE_CLKS = (TAG_DEADLINE_NS * CLK_MHZ) / 1000;
    localparam int IRQ_DELAY_CLKS = 1;
    localparam int VECTOR_CLKS = 4;
    localparam logic [3:0] A_TX_MASK = 4'h0;
    localparam logic [3:0] A_RX_MASK = 4'h1;
    localparam logic [3:0] A_CTRL = 4'h2;
    localparam logic [3:0] A_STATUS = 4'h3;
    localparam logic [3:0] A_TXBUF = 4'h4;
    localparam logic [3:0] A_TXIDX = 4'h5;
    localparam logic [3:0] A_RXBUF = 4'h8;
endpackage

// ---- src/tdmsp_top.sv ----
// TDM serial port: 16 slots of 16 bits, tx DMA buffer 7 words, rx buffer 5.
// Assumes bit clock, frame sync and rx data are async pins from the codec.
// Behaviour
// - Transmit buffer seven words, slots zero to six
// - Slots five and six send zero
// - Receive mask resets to channels zero-four
// - Transmit mask resets to channels zero-six
// - Tag word resets to 0xe000
// - Slot one resets to 0x7400
// - Slot two resets to 0xff80
// - Unused slots send zero words
// - Tx irq after left/right received
// - Tag deadline window counted after tx irq
// - Late tag leaves next frame, flagged
// - Irq one cycle after word's last bit
// - Vectoring takes four port clock cycles
// - Next tag preloaded into shift register, slot one word into holding register
// - Audio handled from transmit interrupt
// - Dual mode unmasks both interrupts
// - Fixed rate rx processing allowed
// - Reload preloads two words, count minus two
// - Tx irq when tx count zero
// - Sixteen 16-bit slots per frame
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module tdmsp_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bit_clk,
    input wire logic frame_sync,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic tx_irq,
    output logic rx_irq,
    output logic tag_late,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    logic [2:0] bclk_s_q, bclk_s_d;
    logic [1:0] fs_s_q, fs_s_d;
    logic [1:0] din_s_q, din_s_d;
    logic [31:0] tx_mask_q, tx_mask_d, rx_mask_q, rx_mask_d;
    logic tx_irq_mask_bit_q, tx_irq_mask_bit_d, rx_irq_mask_bit_q, rx_irq_mask_bit_d;
    logic [15:0] tx_buf_q [tdmsp_pkg::TX_WORDS];
    logic [15:0] tx_buf_d [tdmsp_pkg::TX_WORDS];
    logic [15:0] rx_buf_q [tdmsp_pkg::RX_WORDS];
    logic [15:0] rx_buf_d [tdmsp_pkg::RX_WORDS];
    logic [2:0] txidx_q, txidx_d;
    logic [3:0] slot_q, slot_d;
    logic [3:0] bit_q, bit_d;
    logic [15:0] shreg_q, shreg_d, rxsh_q, rxsh_d;
    logic [15:0] tx_holding_register_q, tx_holding_register_d;
    logic [3:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
    logic in_frame_q, in_frame_d;
    logic rx_on_q, rx_on_d, hold_full_q, hold_full_d;
    logic [3:0] rbit_q, rbit_d, rslot_q, rslot_d;
    logic out_q, out_d;
    logic txp_q, txp_d, rxp_q, rxp_d;
    logic [2:0] txv_q, txv_d, rxv_q, rxv_d;
    logic txi_q, txi_d, rxi_q, rxi_d;
    logic [7:0] dl_q, dl_d;
    logic tag_wr_q, tag_wr_d, late_q, late_d;
    logic [31:0] rdata_q, rdata_d;
    logic rise, fall, fs_hi;

    assign rise = bclk_s_q[1] & ~bclk_s_q[2];
    assign fall = ~bclk_s_q[1] & bclk_s_q[2];
    assign fs_hi = fs_s_q[1];

    always_comb begin
        bclk_s_d = {bclk_s_q[1:0], bit_clk};
        fs_s_d = {fs_s_q[0], frame_sync};
        din_s_d = {din_s_q[0], sdata_in};
        tx_mask_d = tx_mask_q;
        rx_mask_d = rx_mask_q;
        tx_irq_mask_bit_d = tx_irq_mask_bit_q;
        rx_irq_mask_bit_d = rx_irq_mask_bit_q;
        tx_buf_d = tx_buf_q;
        rx_buf_d = rx_buf_q;
        txidx_d = txidx_q;
        slot_d = slot_q;
        bit_d = bit_q;
        shreg_d = shreg_q;
        rxsh_d = rxsh_q;
        tx_holding_register_d = tx_holding_register_q;
        tx_cnt_d = tx_cnt_q;
        rx_cnt_d = rx_cnt_q;
        in_frame_d = in_frame_q;
        rx_on_d = rx_on_q;
        rbit_d = rbit_q;
        rslot_d = rslot_q;
        hold_full_d = hold_full_q;
        out_d = out_q;
        txp_d = 1'b0;
        rxp_d = 1'b0;
        txv_d = {txv_q[1:0], txp_q};
        rxv_d = {rxv_q[1:0], rxp_q};
        txi_d = 1'b0;
        rxi_d = 1'b0;
        dl_d = (dl_q != 8'h00) ? dl_q - 8'h01 : dl_q;
        tag_wr_d = tag_wr_q;
        late_d = late_q;
        rdata_d = 32'h00000000;
        // Receive sampling on rising bit clock
        // Own bit count: the tx count steps on the fall before each last bit,
        // so sharing it would close every word one bit early
        if (rise && rx_on_q) begin
            rxsh_d = {rxsh_q[14:0], din_s_q[1]};
            rbit_d = rbit_q + 4'h1;
            if (rbit_q == 4'hf) begin
                rslot_d = rslot_q + 4'h1;
                if (rslot_q == 4'(tdmsp_pkg::SLOTS - 1)) begin
                    rx_on_d = 1'b0;
                end
                if (rx_mask_q[rslot_q] && rx_cnt_q != 4'h0) begin
                    rx_buf_d[3'(tdmsp_pkg::RX_WORDS - int'(rx_cnt_q))] = {rxsh_q[14:0], din_s_q[1]};
                    rx_cnt_d = rx_cnt_q - 4'h1;
                    if (rx_cnt_q == 4'h1) begin
                        rxp_d = 1'b1;
                        rx_cnt_d = 4'(tdmsp_pkg::RX_WORDS);
                    end
                end
            end
        end
        // Transmit shifting on falling bit clock
        if (fall) begin
            if (fs_hi && !in_frame_q) begin
                in_frame_d = 1'b1;
                rx_on_d = 1'b1;
                rbit_d = 4'h0;
                rslot_d = 4'h0;
                slot_d = 4'h0;
                bit_d = 4'h1;
                out_d = tx_mask_q[0] ? shreg_q[15] : 1'b0;
                shreg_d = {shreg_q[14:0], 1'b0};
            end else if (in_frame_q) begin
                bit_d = bit_q + 4'h1;
                out_d = tx_mask_q[slot_q] ? shreg_q[15] : 1'b0;
                shreg_d = {shreg_q[14:0], 1'b0};
                if (bit_q == 4'hf) begin
                    slot_d = slot_q + 4'h1;
                    if (slot_q == 4'(tdmsp_pkg::SLOTS - 1)) begin
                        in_frame_d = 1'b0;
                    end
                    // Each fetch refills holding; the irq waits until the last
                    // fetched word moves on, so rx left/right are already in
                    if (tx_mask_q[slot_d] && hold_full_q) begin
                        shreg_d = tx_holding_register_q;
                        hold_full_d = 1'b0;
                        if (tx_cnt_q != 4'h0) begin
                            tx_holding_register_d =
                                tx_buf_q[3'(tdmsp_pkg::TX_WORDS - int'(tx_cnt_q))];
                            tx_cnt_d = tx_cnt_q - 4'h1;
                            hold_full_d = 1'b1;
                        end else begin
                            txp_d = 1'b1;
                        end
                    end else begin
                        shreg_d = tdmsp_pkg::ZERO_WORD;
                    end
                    if (tx_cnt_q == 4'h0 && slot_q == 4'(tdmsp_pkg::SLOTS - 1)) begin
                        // Reload: two words queued, frame waits for sync
                        shreg_d = tx_buf_q[0];
                        tx_holding_register_d = tx_buf_q[1];
                        tx_cnt_d = 4'(tdmsp_pkg::TX_WORDS - 2);
                        hold_full_d = 1'b1;
                        tag_wr_d = 1'b0;
                    end
                end
            end
        end
        // Vectoring latency and deadline window
        if (txv_q[2] && tx_irq_mask_bit_q) begin
            txi_d = 1'b1;
            dl_d = 8'(tdmsp_pkg::TAG_DEADLINE_CLKS);
        end
        if (rxv_q[2] && rx_irq_mask_bit_q) begin
            rxi_d = 1'b1;
        end
        if (wr) begin
            unique case (addr)
                tdmsp_pkg::A_TX_MASK: tx_mask_d = wdata;
                tdmsp_pkg::A_RX_MASK: rx_mask_d = wdata;
                tdmsp_pkg::A_CTRL: begin
                    tx_irq_mask_bit_d = wdata[0];
                    rx_irq_mask_bit_d = wdata[1];
                end
                tdmsp_pkg::A_TXBUF: begin
                    if (txidx_q < 3'(tdmsp_pkg::TX_WORDS)) begin
                        tx_buf_d[txidx_q] = wdata[15:0];
                    end
                    if (txidx_q == 3'h0) begin
                        tag_wr_d = 1'b1;
                        if (dl_q == 8'h00) begin
                            late_d = 1'b1;
                        end
                    end
                end
                tdmsp_pkg::A_TXIDX: txidx_d = wdata[2:0];
                tdmsp_pkg::A_STATUS: late_d = late_q & ~wdata[0];
                default: ;
            endcase
        end
        if (rd) begin
            unique case (addr)
                tdmsp_pkg::A_TX_MASK: rdata_d = tx_mask_q;
                tdmsp_pkg::A_RX_MASK: rdata_d = rx_mask_q;
                tdmsp_pkg::A_CTRL: rdata_d = {30'h0, rx_irq_mask_bit_q, tx_irq_mask_bit_q};
                tdmsp_pkg::A_STATUS: rdata_d = {20'h0, tx_cnt_q, rx_cnt_q, 1'b0, in_frame_q, tag_wr_q, late_q};
                tdmsp_pkg::A_TXIDX: rdata_d = {29'h0, txidx_q};
                4'h8, 4'h9, 4'ha, 4'hb, 4'hc: rdata_d = {16'h0, rx_buf_q[3'(addr - tdmsp_pkg::A_RXBUF)]};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bclk_s_q <= 3'h0;
            fs_s_q <= 2'h0;
            din_s_q <= 2'h0;
            tx_mask_q <= tdmsp_pkg::TX_MASK_RST;
            rx_mask_q <= tdmsp_pkg::RX_MASK_RST;
            tx_irq_mask_bit_q <= 1'b1;
            rx_irq_mask_bit_q <= 1'b0;
            tx_buf_q[0] <= tdmsp_pkg::TAG_RST;
            tx_buf_q[1] <= tdmsp_pkg::CMD_RST;
            tx_buf_q[2] <= tdmsp_pkg::DATA_RST;
            for (int i = 3; i < tdmsp_pkg::TX_WORDS; i++) begin
                tx_buf_q[i] <= tdmsp_pkg::ZERO_WORD;
            end
            for (int i = 0; i < tdmsp_pkg::RX_WORDS; i++) begin
                rx_buf_q[i] <= tdmsp_pkg::ZERO_WORD;
            end
            txidx_q <= 3'h0;
            slot_q <= 4'h0;
            bit_q <= 4'h0;
            shreg_q <= tdmsp_pkg::TAG_RST;
            tx_holding_register_q <= tdmsp_pkg::CMD_RST;
            tx_cnt_q <= 4'(tdmsp_pkg::TX_WORDS - 2);
            rx_cnt_q <= 4'(tdmsp_pkg::RX_WORDS);
            in_frame_q <= 1'b0;
            rx_on_q <= 1'b0;
            rbit_q <= 4'h0;
            rslot_q <= 4'h0;
            // Reset counts as the first preload, so holding is full
            hold_full_q <= 1'b1;
            out_q <= 1'b0;
            txp_q <= 1'b0;
            rxp_q <= 1'b0;
            txv_q <= 3'h0;
            rxv_q <= 3'h0;
            txi_q <= 1'b0;
            rxi_q <= 1'b0;
            dl_q <= 8'h00;
            tag_wr_q <= 1'b0;
            late_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            bclk_s_q <= bclk_s_d;
            fs_s_q <= fs_s_d;
            din_s_q <= din_s_d;
            tx_mask_q <= tx_mask_d;
            rx_mask_q <= rx_mask_d;
            tx_irq_mask_bit_q <= tx_irq_mask_bit_d;
            rx_irq_mask_bit_q <= rx_irq_mask_bit_d;
            tx_buf_q <= tx_buf_d;
            rx_buf_q <= rx_buf_d;
            txidx_q <= txidx_d;
            slot_q <= slot_d;
            bit_q <= bit_d;
            shreg_q <= shreg_d;
            rxsh_q <= rxsh_d;
            tx_holding_register_q <= tx_holding_register_d;
            tx_cnt_q <= tx_cnt_d;
            rx_cnt_q <= rx_cnt_d;
            in_frame_q <= in_frame_d;
            rx_on_q <= rx_on_d;
            rbit_q <= rbit_d;
            rslot_q <= rslot_d;
            hold_full_q <= hold_full_d;
            out_q <= out_d;
            txp_q <= txp_d;
            rxp_q <= rxp_d;
            txv_q <= txv_d;
            rxv_q <= rxv_d;
            txi_q <= txi_d;
            rxi_q <= rxi_d;
            dl_q <= dl_d;
            tag_wr_q <= tag_wr_d;
            late_q <= late_d;
            rdata_q <= rdata_d;
        end
    end

    assign sdata_out = out_q;
    assign tx_irq = txi_q;
    assign rx_irq = rxi_q;
    assign tag_late = late_q;
    assign rdata = rdata_q;
endmodule

// ---- test/tdmsp_properties.sv ----
// Port checker for the TDM slot serial port.
// Assumes each frame starts at a rise of frame_sync.
`timescale 1ns/1ps
module tdmsp_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic frame_sync,
    input wire logic tx_irq,
    input wire logic rx_irq,
    input wire logic tag_late,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata
);
    logic fs_q, fs_d, clr;
    logic [11:0] cnt_q, cnt_d;
    assign clr = wr && addr == tdmsp_pkg::A_STATUS && wdata[0];
    always_comb begin
        fs_d = frame_sync;
        // Saturates so a stalled link never wraps into a valid slot
        cnt_d = (cnt_q == 12'hfff) ? cnt_q : cnt_q + 12'h001;
        if (frame_sync && !fs_q) begin
            cnt_d = 12'h000;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fs_q <= 1'b0;
            cnt_q <= 12'hfff;
        end else begin
            fs_q <= fs_d;
            cnt_q <= cnt_d;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside answer cycle");
    tx_pulse_a: assert property (tx_irq |=> !tx_irq)
        else $error("tx irq too long");
    rx_pulse_a: assert property (rx_irq |=> !rx_irq)
        else $error("rx irq too long");
    tx_slot_a: assert property (tx_irq |-> cnt_q inside {[1180:1240]})
        else $error("tx irq not at end of slot five");
    rx_slot_a: assert property (rx_irq |-> cnt_q inside {[980:1040]})
        else $error("rx irq not at end of slot four");
    late_clear_a: assert property (clr |=> !tag_late)
        else $error("late flag not cleared");
    late_hold_a: assert property (tag_late && !clr |=> tag_late)
        else $error("late flag dropped");
    late_cause_a: assert property ($rose(tag_late) |-> $past(wr) && $past(addr) == tdmsp_pkg::A_TXBUF)
        else $error("late flag without buffer write");
    cover property (tx_irq);
    cover property (rx_irq);
    cover property ($rose(tag_late));
endmodule
bind tdmsp_top tdmsp_properties chk_u (.clk(clk), .rst_n(rst_n), .frame_sync(frame_sync), .tx_irq(tx_irq),
    .rx_irq(rx_irq), .tag_late(tag_late), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

// ---- test/tdmsp_codec.sv ----
// Codec model: bit clock, frame sync, sends and captures sixteen slots.
// Assumes the port shifts on bit clock fall and samples on rise.
`timescale 1ns/1ps
module tdmsp_codec (
    input wire logic run,
    input wire logic [15:0] s,
    input wire logic sdata_out,
    output logic bit_clk,
    output logic frame_sync,
    output logic sdata_in,
    output logic [15:0] got [16],
    output int frames
);
    logic [15:0] cur [16];
    logic [15:0] w;
    initial begin
        bit_clk = 1'b0;
        frame_sync = 1'b0;
        sdata_in = 1'b0;
        frames = 0;
        forever begin
            wait (run);
            #62.5 bit_clk = 1'b1;
            frame_sync = 1'b1;
            #62.5 bit_clk = 1'b0;
            for (int i = 0; i < 256; i++) begin
                w = s + 16'(i / 16);
                sdata_in = w[15 - i % 16];
                #62.5 bit_clk = 1'b1;
                frame_sync = 1'b0;
                cur[i / 16][15 - i % 16] = sdata_out;
                #62.5 bit_clk = 1'b0;
            end
            got = cur;
            frames++;
        end
    end
endmodule

// ---- test/tdm_slot_dma_serial_port_test.sv ----
// Bench for the TDM slot serial port with a codec model on the link.
// Assumes the checker is bound inside the top module.
`timescale 1ns/1ps
module tdm_slot_dma_serial_port_test;
    logic clk, rst_n, wr, rd, run, tag_late, sdata_out, tx_irq, rx_irq, bit_clk, frame_sync, sdata_in;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, seed, v;
    logic [15:0] s, es, tag, left;
    logic [15:0] got [16];
    int frames, fails, compares;
    tdmsp_top dut_u (.clk(clk), .rst_n(rst_n), .bit_clk(bit_clk), .frame_sync(frame_sync), .sdata_in(sdata_in),
        .sdata_out(sdata_out), .tx_irq(tx_irq), .rx_irq(rx_irq), .tag_late(tag_late), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    tdmsp_codec codec_u (.run(run), .s(s), .sdata_out(sdata_out), .bit_clk(bit_clk), .frame_sync(frame_sync),
        .sdata_in(sdata_in), .got(got), .frames(frames));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_tx;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (tx_irq !== 1'b1 && n < 5000);
        chk("tx irq", {31'h0, tx_irq}, 32'h1);
    endtask
    function automatic logic [15:0] tx_exp(input int f, input int k);
        logic [15:0] rb [3];
        rb = '{tdmsp_pkg::TAG_RST, tdmsp_pkg::CMD_RST, tdmsp_pkg::DATA_RST};
        if (f == 1 && k == 0) return tag;
        if (f > 0 && k == 3) return left;
        return (k < 3) ? rb[k] : tdmsp_pkg::ZERO_WORD;
    endfunction
    task automatic end_of_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        logic [3:0] ra [4];
        logic [31:0] rv [4];
        ra = '{tdmsp_pkg::A_TX_MASK, tdmsp_pkg::A_RX_MASK, tdmsp_pkg::A_STATUS, 4'h6};
        rv = '{tdmsp_pkg::TX_MASK_RST, tdmsp_pkg::RX_MASK_RST, 32'h00000550, 32'h0};
        seed = 32'hecfb9226;
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        run = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        s = 16'($random(seed));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rreg(ra[i]);
            chk("reset reg", v, rv[i]);
        end
        wreg(tdmsp_pkg::A_CTRL, 32'h3);
        $display("registers done");
        run = 1'b1;
        for (int f = 0; f < 3; f++) begin
            es = s;
            wait_tx();
            for (int k = 0; k < 5; k++) begin
                rreg(tdmsp_pkg::A_RXBUF + 4'(k));
                chk("rx word", {16'h0, v[15:0]}, {16'h0, es + 16'(k)});
            end
            s = 16'($random(seed));
            if (f == 0) begin
                tag = 16'($random(seed));
                left = 16'($random(seed));
                wreg(tdmsp_pkg::A_TXIDX, 32'h0);
                wreg(tdmsp_pkg::A_TXBUF, {16'h0, tag});
                wreg(tdmsp_pkg::A_TXIDX, 32'h3);
                wreg(tdmsp_pkg::A_TXBUF, {16'h0, left});
                #1 chk("in time", {31'h0, tag_late}, 32'h0);
            end
            if (f == 1) begin
                // Past the window, so the tag write must be flagged
                repeat (130) @(posedge clk);
                wreg(tdmsp_pkg::A_TXIDX, 32'h0);
                wreg(tdmsp_pkg::A_TXBUF, {16'h0, tdmsp_pkg::TAG_RST});
                @(posedge clk);
                #1 chk("late", {31'h0, tag_late}, 32'h1);
                wreg(tdmsp_pkg::A_STATUS, 32'h1);
                @(posedge clk);
                #1 chk("cleared", {31'h0, tag_late}, 32'h0);
            end
            wait (frames == f + 1);
            for (int k = 0; k < 16; k++) begin
                chk("tx slot", {16'h0, got[k]}, {16'h0, tx_exp(f, k)});
            end
            $display("frame %0d done", f);
        end
        end_of_test();
    end
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        end_of_test();
    end
endmodule
